//--- design/pes_top.sv
/*
  Performance event selector and counter: decodes event code and unit mask,
  picks a core or cache source, qualifies it by edge and adds it to a counter.
  Assumes all inputs synchronous to sys_clk and a strobed register port.
*/
// Overview of operation
// - Page walk code, mask 03, edge set: count one per walk started.
// - Page walk code, mask 03, edge clear: count each cycle a walk runs.
// - Code 10 mask 01: count executed x87 compute micro-ops, speculative too.
// - Code 10 mask 81: count x87 compute micro-ops at retirement only.
// - Code 11 mask 01 or 81: count floating-point operations needing microcode help.
// - Code 12: count multiplies; mask 01 executed, mask 81 retired.
// - Code 13: count divides and square roots; mask 01 executed, 81 retired.
// - Code 14 mask 01: count each cycle the divider is busy.
// - Code 21: count cycles the cache address bus carries an access.
// - Code 22: count data bus return cycles; full line adds two.
// - Code 24: count cache fills, demand and prefetch selectable.
// - Code 25: count dirty lines written back into the cache.
// - Code 26: count evicted lines, demand and prefetch selectable.
// - Code 27: count dirty evicted lines, demand and prefetch selectable.
// - Code 28: count cacheable instruction line requests, filtered by line state.
// - Cache events count for the local core or both sharing cores.
`timescale 1ns/100ps
module pes_top #(
  parameter int CNT_W = 40
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [pes_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rd_data,
  input wire pes_pkg::pes_core_src_type core_src,
  input wire pes_pkg::pes_l2_src_type [pes_pkg::NUM_CORES-1:0] l2_src
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // High word holds bits above 31, so the counter needs 33 to 64 bits
  if (CNT_W < 33 || CNT_W > 64) begin : g_bad_width
    $error("pes_top: CNT_W must lie between 33 and 64");
  end

  // Cache sum is three bits: two per core, three cores at most
  if (pes_pkg::NUM_CORES < 1 || pes_pkg::NUM_CORES > 3) begin : g_bad_cores
    $error("pes_top: NUM_CORES must lie between 1 and 3");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  pes_pkg::pes_ctrl_type ctrl_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W:0] count_sum;
  logic wrap_reg;
  logic match_reg;
  logic level_reg;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;

  logic [1:0] core_amount;
  logic core_match;
  logic l2_code;
  logic [1:0] l2_amount [pes_pkg::NUM_CORES];
  logic [pes_pkg::NUM_CORES-1:0] l2_core_match;
  logic [pes_pkg::NUM_CORES-1:0] l2_core_used;
  logic [2:0] l2_total;
  logic [2:0] sel_amount;
  logic sel_match;
  logic sel_level;
  logic sel_rise;
  logic [2:0] inc_amount;
  logic scope_both;
  logic count_load;
  logic wrap_set;

  logic wr_ctrl;
  logic wr_count_lo;
  logic wr_count_hi;
  logic wr_status;

  ////////////////////////////////////////////////////////////////////////////////
  // Register write decode

  always_comb begin
    wr_ctrl = 1'b0;
    wr_count_lo = 1'b0;
    wr_count_hi = 1'b0;
    wr_status = 1'b0;
    if (wr_strobe) begin
      if (addr == pes_pkg::OFS_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (addr == pes_pkg::OFS_COUNT_LO) begin
        wr_count_lo = 1'b1;
      end else if (addr == pes_pkg::OFS_COUNT_HI) begin
        wr_count_hi = 1'b1;
      end else if (addr == pes_pkg::OFS_STATUS) begin
        wr_status = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= pes_pkg::pes_ctrl_type'(pes_pkg::CTRL_RESET[17:0]);
    end else if (wr_ctrl) begin
      ctrl_reg.code <= wr_data[pes_pkg::CTRL_CODE_LSB +: 8];
      ctrl_reg.umask <= wr_data[pes_pkg::CTRL_UMASK_LSB +: 8];
      ctrl_reg.edge_trig <= wr_data[pes_pkg::CTRL_EDGE_BIT];
      ctrl_reg.enable <= wr_data[pes_pkg::CTRL_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core pipeline event decode

  // Masks other than the listed ones stay unmatched
  always_comb begin
    core_amount = 2'h0;
    core_match = 1'b0;
    case (ctrl_reg.code)
      pes_pkg::EVT_PAGE_WALK: begin
        // Level only; the edge qualifier turns it into walk starts
        if (ctrl_reg.umask == pes_pkg::UMASK_WALK) begin
          core_match = 1'b1;
          core_amount = {1'b0, core_src.page_walk_active};
        end
      end
      pes_pkg::EVT_FP_COMP: begin
        if (ctrl_reg.umask == pes_pkg::UMASK_EXEC) begin
          core_match = 1'b1;
          core_amount = {1'b0, core_src.fp_compute_uops_executed};
        end else if (ctrl_reg.umask == pes_pkg::UMASK_RETIRE) begin
          core_match = 1'b1;
          core_amount = {1'b0, core_src.fp_compute_uops_retired};
        end
      end
      pes_pkg::EVT_FP_HELP: begin
        if (ctrl_reg.umask == pes_pkg::UMASK_EXEC) begin
          core_match = 1'b1;
          core_amount = {1'b0, core_src.fp_microcode_help_executed};
        end else if (ctrl_reg.umask == pes_pkg::UMASK_RETIRE) begin
          core_match = 1'b1;
          core_amount = {1'b0, core_src.fp_microcode_help_retired};
        end
      end
      pes_pkg::EVT_MUL: begin
        if (ctrl_reg.umask == pes_pkg::UMASK_EXEC) begin
          core_match = 1'b1;
          core_amount = {1'b0, core_src.multiply_executed};
        end else if (ctrl_reg.umask == pes_pkg::UMASK_RETIRE) begin
          core_match = 1'b1;
          core_amount = {1'b0, core_src.multiply_retired};
        end
      end
      pes_pkg::EVT_DIV: begin
        if (ctrl_reg.umask == pes_pkg::UMASK_EXEC) begin
          core_match = 1'b1;
          core_amount = {1'b0, core_src.divide_executed};
        end else if (ctrl_reg.umask == pes_pkg::UMASK_RETIRE) begin
          core_match = 1'b1;
          core_amount = {1'b0, core_src.divide_retired};
        end
      end
      pes_pkg::EVT_DIV_BUSY: begin
        if (ctrl_reg.umask == pes_pkg::UMASK_EXEC) begin
          core_match = 1'b1;
          core_amount = {1'b0, core_src.divider_busy};
        end
      end
      default: begin
        core_match = 1'b0;
        core_amount = 2'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Second-level cache events, one decoder per sharing core

  assign scope_both = ctrl_reg.umask[pes_pkg::UM_SCOPE_LSB +: 2] == pes_pkg::SCOPE_BOTH;

  for (genvar i = 0; i < pes_pkg::NUM_CORES; i++) begin : g_core
    pes_l2_amount u_l2_amount (
      .code(ctrl_reg.code),
      .umask(ctrl_reg.umask),
      .src(l2_src[i]),
      .amount(l2_amount[i]),
      .match(l2_core_match[i])
    );
    // Entry 0 is the local core; the rest join only in both-core scope
    assign l2_core_used[i] = (i == 0) || scope_both;
  end

  // Every core decodes the same code, so the local one speaks
  assign l2_code = l2_core_match[0];

  // Out-of-scope cores still decode; their amounts are dropped
  always_comb begin
    l2_total = 3'h0;
    for (int i = 0; i < pes_pkg::NUM_CORES; i++) begin
      if (l2_core_used[i]) begin
        l2_total = 3'(l2_total + {1'b0, l2_amount[i]});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Selection and edge qualifier

  always_comb begin
    if (core_match) begin
      sel_match = 1'b1;
      sel_amount = {1'b0, core_amount};
    end else if (l2_code) begin
      sel_match = 1'b1;
      sel_amount = l2_total;
    end else begin
      sel_match = 1'b0;
      sel_amount = 3'h0;
    end
  end

  assign sel_level = sel_amount != 3'h0;

  // Back-to-back walks with no idle cycle count as one start
  pes_rise_detect u_rise (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .level(sel_level),
    .rise(sel_rise)
  );

  // Edge mode adds one per rise, whatever the amount
  always_comb begin
    if (!ctrl_reg.enable || !sel_match) begin
      inc_amount = 3'h0;
    end else if (ctrl_reg.edge_trig) begin
      inc_amount = {2'h0, sel_rise};
    end else begin
      inc_amount = sel_amount;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter

  // Spare top bit keeps the carry out for the wrap flag
  assign count_sum = {1'b0, count_reg} + {{(CNT_W - 2){1'b0}}, inc_amount};

  assign count_load = wr_count_lo || wr_count_hi;

  always_comb begin
    count_next = count_sum[CNT_W-1:0];
    // Software load wins; an event in the same cycle is dropped
    if (wr_count_lo) begin
      count_next = {count_reg[CNT_W-1:32], wr_data};
    end else if (wr_count_hi) begin
      count_next = {wr_data[CNT_W-33:0], count_reg[31:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags

  // A load is not an overflow, so no wrap on counter writes
  assign wrap_set = count_sum[CNT_W] && !count_load;

  // Wrap flag: hardware set wins over a software clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrap_reg <= 1'b0;
    end else if (wrap_set) begin
      wrap_reg <= 1'b1;
    end else if (wr_status && wr_data[pes_pkg::STAT_WRAP_BIT]) begin
      wrap_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= sel_match;
    end
  end

  // Level before the edge qualifier, for software polling
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= sel_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read

  // Count halves are read apart, so a read is not atomic
  always_comb begin
    rd_data_next = 32'h0000_0000;
    if (rd_strobe) begin
      if (addr == pes_pkg::OFS_CTRL) begin
        rd_data_next[pes_pkg::CTRL_CODE_LSB +: 8] = ctrl_reg.code;
        rd_data_next[pes_pkg::CTRL_UMASK_LSB +: 8] = ctrl_reg.umask;
        rd_data_next[pes_pkg::CTRL_EDGE_BIT] = ctrl_reg.edge_trig;
        rd_data_next[pes_pkg::CTRL_EN_BIT] = ctrl_reg.enable;
      end else if (addr == pes_pkg::OFS_COUNT_LO) begin
        rd_data_next = count_reg[31:0];
      end else if (addr == pes_pkg::OFS_COUNT_HI) begin
        rd_data_next[CNT_W-33:0] = count_reg[CNT_W-1:32];
      end else if (addr == pes_pkg::OFS_STATUS) begin
        rd_data_next[pes_pkg::STAT_MATCH_BIT] = match_reg;
        rd_data_next[pes_pkg::STAT_LEVEL_BIT] = level_reg;
        rd_data_next[pes_pkg::STAT_WRAP_BIT] = wrap_reg;
      end
    end
  end

  // Data stand for one cycle only, zero otherwise
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_reg <= 32'h0000_0000;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
endmodule

//--- pkg/pes_pkg.sv
/*
  Constants, field layouts and carrier types for the event selector and counter.
  Assumes a single core clock and event sources synchronous to it.
*/
package pes_pkg;
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT_LO = 8'h04;
  localparam logic [7:0] OFS_COUNT_HI = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  // Control word fields
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_UMASK_LSB = 8;
  localparam int CTRL_EDGE_BIT = 18;
  localparam int CTRL_EN_BIT = 22;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status word fields
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_LEVEL_BIT = 1;
  localparam int STAT_WRAP_BIT = 2;
  // Event codes
  localparam logic [7:0] EVT_PAGE_WALK = 8'h0c;
  localparam logic [7:0] EVT_FP_COMP = 8'h10;
  localparam logic [7:0] EVT_FP_HELP = 8'h11;
  localparam logic [7:0] EVT_MUL = 8'h12;
  localparam logic [7:0] EVT_DIV = 8'h13;
  localparam logic [7:0] EVT_DIV_BUSY = 8'h14;
  localparam logic [7:0] EVT_L2_ADDR = 8'h21;
  localparam logic [7:0] EVT_L2_DBUS = 8'h22;
  localparam logic [7:0] EVT_L2_FILL = 8'h24;
  localparam logic [7:0] EVT_L2_WB_IN = 8'h25;
  localparam logic [7:0] EVT_L2_EVICT = 8'h26;
  localparam logic [7:0] EVT_L2_DEVICT = 8'h27;
  localparam logic [7:0] EVT_L2_INSTR = 8'h28;
  // Unit masks and unit-mask fields of the second-level cache events
  localparam logic [7:0] UMASK_WALK = 8'h03;
  localparam logic [7:0] UMASK_EXEC = 8'h01;
  localparam logic [7:0] UMASK_RETIRE = 8'h81;
  localparam int UM_STATE_LSB = 0;
  localparam int UM_DEMAND_BIT = 4;
  localparam int UM_PREFETCH_BIT = 5;
  localparam int UM_SCOPE_LSB = 6;
  localparam logic [1:0] SCOPE_SELF = 2'h1;
  localparam logic [1:0] SCOPE_BOTH = 2'h3;
  localparam logic [1:0] AMT_FULL_LINE = 2'h2;
  localparam int NUM_CORES = 2;

  typedef struct packed {
    logic enable;
    logic edge_trig;
    logic [7:0] umask;
    logic [7:0] code;
  } pes_ctrl_type;

  // Pipeline sources of the local core
  typedef struct packed {
    logic page_walk_active;
    logic fp_compute_uops_executed;
    logic fp_compute_uops_retired;
    logic fp_microcode_help_executed;
    logic fp_microcode_help_retired;
    logic multiply_executed;
    logic multiply_retired;
    logic divide_executed;
    logic divide_retired;
    logic divider_busy;
  } pes_core_src_type;

  // Second-level cache sources, one set per core sharing the cache
  typedef struct packed {
    logic second_level_addr_bus_cycles;
    logic second_level_data_bus_cycles;
    logic data_bus_full_line;
    logic fill_demand;
    logic fill_prefetch;
    logic second_level_dirty_writebacks_in;
    logic evict_demand;
    logic evict_prefetch;
    logic dirty_evict_demand;
    logic dirty_evict_prefetch;
    logic second_level_instr_requests;
    logic instr_uncacheable;
    logic instr_tlb_miss;
    logic [3:0] instr_line_state;
  } pes_l2_src_type;
endpackage

//--- design/pes_rise_detect.sv
/*
  Rising-edge qualifier: a one-cycle pulse when the level goes from low to high.
  Assumes the level is synchronous to sys_clk.
*/
`timescale 1ns/100ps
module pes_rise_detect (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic level,
  output logic rise
);
  logic prev_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
endmodule

//--- design/pes_l2_amount.sv
/*
  Per-core amount for the second-level cache events.
  Assumes one source set per core; the caller merges cores by scope.
*/
`timescale 1ns/100ps
module pes_l2_amount (
  input wire logic [7:0] code,
  input wire logic [7:0] umask,
  input wire pes_pkg::pes_l2_src_type src,
  output logic [1:0] amount,
  output logic match
);
  logic dem_sel;
  logic pf_sel;
  logic [1:0] scope;

  assign dem_sel = umask[pes_pkg::UM_DEMAND_BIT];
  assign pf_sel = umask[pes_pkg::UM_PREFETCH_BIT];
  assign scope = umask[pes_pkg::UM_SCOPE_LSB +: 2];

  always_comb begin
    amount = 2'h0;
    match = (scope == pes_pkg::SCOPE_SELF) || (scope == pes_pkg::SCOPE_BOTH);
    case (code)
      pes_pkg::EVT_L2_ADDR: amount = {1'b0, src.second_level_addr_bus_cycles};
      pes_pkg::EVT_L2_DBUS: begin
        // Full line moves two beats, so it counts two
        if (src.second_level_data_bus_cycles) begin
          amount = src.data_bus_full_line ? pes_pkg::AMT_FULL_LINE : 2'h1;
        end
      end
      pes_pkg::EVT_L2_FILL: begin
        amount = 2'({1'b0, src.fill_demand & dem_sel}
          + {1'b0, src.fill_prefetch & pf_sel});
      end
      pes_pkg::EVT_L2_WB_IN: amount = {1'b0, src.second_level_dirty_writebacks_in};
      pes_pkg::EVT_L2_EVICT: begin
        amount = 2'({1'b0, src.evict_demand & dem_sel}
          + {1'b0, src.evict_prefetch & pf_sel});
      end
      pes_pkg::EVT_L2_DEVICT: begin
        amount = 2'({1'b0, src.dirty_evict_demand & dem_sel}
          + {1'b0, src.dirty_evict_prefetch & pf_sel});
      end
      pes_pkg::EVT_L2_INSTR: begin
        amount = {1'b0, src.second_level_instr_requests & ~src.instr_uncacheable
          & ~src.instr_tlb_miss
          & (|(src.instr_line_state & umask[pes_pkg::UM_STATE_LSB +: 4]))};
      end
      default: match = 1'b0;
    endcase
  end
endmodule

//--- bench/pes_top_chk.sv
/*
  Checker of the event selector: register port timing and selection match.
  Sees only the top ports; bound from the testbench top file.
*/
`timescale 1ns/100ps
module pes_top_chk #(
  parameter int CNT_W = 40
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [pes_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [31:0] rd_data,
  input wire pes_pkg::pes_core_src_type core_src,
  input wire pes_pkg::pes_l2_src_type [pes_pkg::NUM_CORES-1:0] l2_src
);
  logic [31:0] ctl_reg;
  logic [1:0] age_reg;
  logic [7:0] cc;
  logic [7:0] cm;
  logic core_ok, l2_code, scope_ok, l2_sure, st_rd, lo_rd;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////////
  // Shadow control word; age lets the status match settle first
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_reg <= 32'h0;
    end else if (wr_strobe && addr == pes_pkg::OFS_CTRL) begin
      ctl_reg <= wr_data;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      age_reg <= 2'h0;
    end else if (wr_strobe && addr == pes_pkg::OFS_CTRL) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  assign cc = ctl_reg[7:0];
  assign cm = ctl_reg[15:8];
  assign core_ok = (cc == 8'h0c && cm == 8'h03) || (cc == 8'h14 && cm == 8'h01) ||
    (cc inside {8'h10, 8'h11, 8'h12, 8'h13} && cm inside {8'h01, 8'h81});
  assign l2_code = cc inside {8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28};
  assign scope_ok = cm[7:6] inside {2'h1, 2'h3};
  assign l2_sure = l2_code && scope_ok && (cc inside {8'h21, 8'h22, 8'h25} ||
    (cc == 8'h28 && |cm[3:0]) || (cc inside {8'h24, 8'h26, 8'h27} && cm[4]));
  assign st_rd = rd_strobe && addr == pes_pkg::OFS_STATUS && ctl_reg[22] && age_reg == 2'h3;
  assign lo_rd = rd_strobe && addr == pes_pkg::OFS_COUNT_LO;
  //////////////////////////////////////////////////////////////////////////////
  chk_rd_idle: assert property (!rd_strobe |=> rd_data == 32'h0)
    else $error("read data not zero outside read");
  chk_unmapped_zero: assert property (rd_strobe && !(addr inside {8'h00, 8'h04, 8'h08,
    8'h0c}) |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  chk_walk_match: assert property (st_rd && cc == 8'h0c && cm == 8'h03 |=> rd_data[0])
    else $error("page walk selection not matched");
  chk_fp_match: assert property (st_rd && cc == 8'h10 && core_ok |=> rd_data[0])
    else $error("fp compute selection not matched");
  chk_arith_match: assert property (st_rd && cc inside {8'h11, 8'h12, 8'h13} && core_ok
    |=> rd_data[0])
    else $error("assist, multiply or divide selection not matched");
  chk_busy_match: assert property (st_rd && cc == 8'h14 && cm == 8'h01 |=> rd_data[0])
    else $error("divider busy selection not matched");
  chk_cache_match: assert property (st_rd && l2_sure |=> rd_data[0])
    else $error("cache selection not matched");
  chk_scope_reject: assert property (st_rd && l2_code && !scope_ok |=> !rd_data[0])
    else $error("bad scope matched");
  chk_no_match: assert property (st_rd && !core_ok && !l2_code |=> !rd_data[0])
    else $error("unimplemented selection matched");
  chk_frozen_count: assert property (lo_rd && !ctl_reg[22] && age_reg != 2'h0 ##1 lo_rd
    |=> rd_data == $past(rd_data))
    else $error("count moved while disabled");
endmodule

//--- bench/pes_src_model.sv
/*
  Core pipeline and cache event sources seen by the selector.
  Assumes rnd changes right after a rising edge; idle sources are low.
*/
`timescale 1ns/100ps
module pes_src_model (
  input wire logic active,
  input wire logic [63:0] rnd,
  output pes_pkg::pes_core_src_type core_src,
  output pes_pkg::pes_l2_src_type [pes_pkg::NUM_CORES-1:0] l2_src
);
  always_comb begin
    core_src = '0;
    l2_src = '0;
    if (active) begin
      core_src = pes_pkg::pes_core_src_type'(rnd[9:0]);
      for (int k = 0; k < pes_pkg::NUM_CORES; k++) begin
        l2_src[k] = pes_pkg::pes_l2_src_type'(rnd[10+17*k +: 17]);
        // Full line only rides on a busy data bus
        l2_src[k].data_bus_full_line = l2_src[k].second_level_data_bus_cycles & rnd[44+k];
        l2_src[k].instr_line_state = 4'h1 << rnd[46+2*k +: 2];
      end
    end
  end
endmodule

//--- bench/testbench.sv
/*
  Self-checking bench: programs each selection, drives random sources, checks counts.
  Assumes the source model and checker files are compiled before it.
*/
`timescale 1ns/100ps
module testbench;
  localparam int CNT_W = 40;
  logic sys_clk, resetn, wr_strobe, rd_strobe, src_act;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, seed, d;
  logic [63:0] rnd;
  logic [16:0] tbl [0:25];
  pes_pkg::pes_core_src_type core_src;
  pes_pkg::pes_l2_src_type [pes_pkg::NUM_CORES-1:0] l2_src;
  int n_errors, n_checks;
  pes_top #(.CNT_W(CNT_W)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .core_src(core_src), .l2_src(l2_src));
  pes_src_model u_src (.active(src_act), .rnd(rnd), .core_src(core_src), .l2_src(l2_src));
  //////////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int unsigned er(input logic [7:0] m, input logic e, input logic r);
    return (m == 8'h01) ? e : (m == 8'h81) ? r : 0;
  endfunction
  function automatic int unsigned amt(input logic [7:0] c, input logic [7:0] m);
    int unsigned a;
    pes_pkg::pes_l2_src_type q;
    a = 0;
    case (c)
      8'h0c: a = (m == 8'h03) ? core_src.page_walk_active : 0;
      8'h10: a = er(m, core_src.fp_compute_uops_executed, core_src.fp_compute_uops_retired);
      8'h11: a = er(m, core_src.fp_microcode_help_executed, core_src.fp_microcode_help_retired);
      8'h12: a = er(m, core_src.multiply_executed, core_src.multiply_retired);
      8'h13: a = er(m, core_src.divide_executed, core_src.divide_retired);
      8'h14: a = (m == 8'h01) ? core_src.divider_busy : 0;
      default: begin
        for (int k = 0; k < pes_pkg::NUM_CORES; k++) begin
          q = l2_src[k];
          if (m[7:6] == 2'h3 || (m[7:6] == 2'h1 && k == 0)) begin
            case (c)
              8'h21: a += q.second_level_addr_bus_cycles;
              8'h22: a += q.second_level_data_bus_cycles + q.data_bus_full_line;
              8'h24: a += (m[4] & q.fill_demand) + (m[5] & q.fill_prefetch);
              8'h25: a += q.second_level_dirty_writebacks_in;
              8'h26: a += (m[4] & q.evict_demand) + (m[5] & q.evict_prefetch);
              8'h27: a += (m[4] & q.dirty_evict_demand) + (m[5] & q.dirty_evict_prefetch);
              8'h28: a += q.second_level_instr_requests && !q.instr_uncacheable &&
                !q.instr_tlb_miss && |(q.instr_line_state & m[3:0]);
              default: ;
            endcase
          end
        end
      end
    endcase
    return a;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= v;
    wr_strobe <= 1'b1;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    @(negedge sys_clk);
    v = rd_data;
  endtask
  // Back-to-back reads of one place, no gap between strobes
  task automatic rd2(input logic [7:0] a, output logic [31:0] v0, output logic [31:0] v1);
    @(posedge sys_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    v0 = rd_data;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    @(negedge sys_clk);
    v1 = rd_data;
  endtask
  task automatic run_evt(input logic [16:0] t, input logic [63:0] start);
    logic [63:0] lim, fin;
    logic [31:0] cw, v0, v1, st;
    int unsigned ex, lv, pv;
    lim = 64'h1 << CNT_W;
    cw = {9'h0, 1'b1, 3'h0, t[16], 2'h0, t[15:0]};
    wr(pes_pkg::OFS_CTRL, 32'h0);
    wr(pes_pkg::OFS_COUNT_LO, start[31:0]);
    wr(pes_pkg::OFS_COUNT_HI, start[63:32]);
    wr(pes_pkg::OFS_CTRL, cw);
    rd(pes_pkg::OFS_CTRL, v0);
    check("ctrl", {32'h0, v0 & 32'h0044_ffff}, {32'h0, cw});
    ex = 0;
    pv = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      src_act <= 1'b1;
      rnd <= {xs(), xs()};
      @(negedge sys_clk);
      lv = amt(t[7:0], t[15:8]);
      if (!t[16]) ex += lv;
      else if (lv != 0 && pv == 0) ex++;
      pv = lv;
    end
    @(posedge sys_clk);
    src_act <= 1'b0;
    rd(pes_pkg::OFS_STATUS, st);
    wr(pes_pkg::OFS_CTRL, 32'h0);
    rd2(pes_pkg::OFS_COUNT_LO, v0, v1);
    rd(pes_pkg::OFS_COUNT_HI, cw);
    fin = (start + ex) % lim;
    check("count_lo", {32'h0, v0}, {32'h0, fin[31:0]});
    check("count_lo_again", {32'h0, v1}, {32'h0, fin[31:0]});
    check("count_hi", {32'h0, cw}, {32'h0, fin[63:32]});
    check("wrap", {63'h0, st[2]}, {63'h0, start + ex >= lim});
    wr(pes_pkg::OFS_STATUS, 32'h4);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
  initial begin
    resetn = 1'b0;
    addr = 8'h0;
    wr_data = 32'h0;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    src_act = 1'b0;
    rnd = 64'h0;
    seed = 32'h8fefbf31;
    n_errors = 0;
    n_checks = 0;
    tbl = '{17'h1_030c, 17'h0_0110, 17'h0_030c, 17'h0_8110, 17'h0_0111, 17'h0_8111,
      17'h0_0112, 17'h0_8112, 17'h0_0113, 17'h0_8113, 17'h0_0114, 17'h0_4021,
      17'h0_c021, 17'h0_c022, 17'h1_4022, 17'h0_5024, 17'h0_6024, 17'h0_f024,
      17'h0_c025, 17'h0_7026, 17'h0_d027, 17'h0_4f28, 17'h0_c628, 17'h0_c023,
      17'h0_0312, 17'h0_8021};
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      rd(8'(a), d);
      check("reset_value", {32'h0, d}, 64'h0);
    end
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, d);
    check("unmapped", {32'h0, d}, 64'h0);
    // First entry wraps the counter, second carries into the high word
    run_evt(tbl[0], (64'h1 << CNT_W) - 64'h2);
    run_evt(tbl[1], 64'hffff_fff0);
    for (int i = 2; i < 26; i++) begin
      run_evt(tbl[i], {32'h0, xs()});
    end
    summarize();
  end
endmodule
bind pes_top pes_top_chk #(.CNT_W(CNT_W)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
  .rd_data(rd_data), .core_src(core_src), .l2_src(l2_src));
